// file: dbl_ballast_model.sv
/*
 * Behavioural model of the two lighting lines behind the level bank:
 * each ballast keeps the last level commanded to it, and the line
 * engines report a fault bitmap and an addressed-ballast count.
 * Assumes the bank's clock; status changes land just after an edge.
 */
`timescale 1ns/1ps

module dbl_ballast_model (
    // Clock.
    input wire logic i_clk,
    // Level commands from the bank.
    input wire dbl_pkg::dbl_cmd_t i_cmd,
    // Line status toward the bank.
    output logic [1:0][15:0] o_fault,
    output logic [1:0][15:0] o_count
);
    logic [1:0][15:0][7:0] level_q;
    int cmd_total;

    // A sentinel level shows a ballast that was never commanded.
    initial begin
        o_fault = '0;
        o_count = '0;
        level_q = {32{8'hEE}};
        cmd_total = 0;
    end

    // Each ballast simply takes whatever level arrives for it.
    always @(posedge i_clk) begin
        if (i_cmd.vld === 1'b1) begin
            level_q[i_cmd.line][i_cmd.idx] <= i_cmd.lvl;
            cmd_total <= cmd_total + 1;
        end
    end

    // Bit n of the bitmap stands for ballast n+1 of the line.
    task automatic set_status(input int line, input logic [15:0] flt, input logic [15:0] cnt);
        @(posedge i_clk);
        o_fault[line] <= flt;
        o_count[line] <= cnt;
    endtask
endmodule

// file: dbl_level_bank.sv
/*
 * Ballast level register bank for two lighting lines: setpoint, low and
 * high limit tables, clamped level command issue, local switch stepping,
 * fault and count readback, and the gated replacement trigger.
 * Assumes the register port, switch steps, fault bitmaps and counts all
 * come from logic on the same clock, so none of them is synchronised.
 */
//
// Summary of operation
// (R1) Line one has 16 setpoint registers from 40270, values 0 to 254, reset 0.
// (R2) Line two has 16 setpoint registers from 40286, same range, reset 0.
// (R3) On line one a setpoint of 0 sends the off level and 254 the top level.
// (R4) On line two a setpoint of 0 drives the ballast at its minimum, unlike line one.
// (R5) A set switch dimming block bit makes the line ignore local switch steps.
// (R6) Each line has 16 low-limit registers, from 40334 and 40350, reset 0.
// (R7) A low limit of 0 is the off level and 253 is the largest useful one.
// (R8) Switch dimming down stops at the ballast's low limit.
// (R9) A level below the low limit is driven at the low limit.
// (R10) Each line has 16 high-limit registers, from 40398 and 40414.
// (R11) Switch brightening stops at the high limit and higher levels drive the limit.
// (R12) Every high limit resets to 254, and a limit of 1 keeps the lamp nearly dark.
// (R13) Registers 30258 and 30259 report each line's count of addressed ballasts.
// (R14) Registers 30157 and 30158 hold each line's fault bitmap, bit n for ballast n+1.
// (R15) A replacement request acts on its rising edge only while the fault bitmap is nonzero.
// (R16) Any change of setpoint or limit issues one clamped level command for that ballast.
`timescale 1ns/1ps

module dbl_level_bank (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port.
    input wire dbl_pkg::dbl_req_t i_req,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_ack,
    // Line status from the line engines.
    input wire logic [1:0][15:0] i_fault,
    input wire logic [1:0][15:0] i_count,
    // Local switches and control bits.
    input wire dbl_pkg::dbl_sw_t i_sw,
    input wire logic [1:0] i_dim_block,
    input wire logic [1:0] i_replace_req,
    // Commands toward the lines.
    output dbl_pkg::dbl_cmd_t o_cmd,
    output logic [1:0] o_replace_go
);

    dbl_pkg::dbl_state_t st_r;
    dbl_pkg::dbl_state_t st_nxt;
    logic sel_vld;
    logic sel_line;
    logic [3:0] sel_idx;
    logic [7:0] sel_sp;
    logic [7:0] sel_mn;
    logic [7:0] sel_mx;

    // Level actually sent: low limit first, then high limit, so a high
    // limit below the low limit wins and the lamp never exceeds it.
    function automatic logic [7:0] f_clamp(input logic line, input logic [7:0] sp,
                                           input logic [7:0] mn, input logic [7:0] mx);
        logic [7:0] v;
        v = sp;
        if (!line && sp == dbl_pkg::LVL_OFF) begin
            return dbl_pkg::LVL_OFF; // R3
        end
        if (v < mn) begin
            v = mn; // R9 R4
        end
        if (v > mx) begin
            v = mx; // R11
        end
        return v;
    endfunction

    // Hit test of a 16-entry table; the entry index is the low nibble of
    // the distance because no table base is nibble aligned.
    function automatic logic f_hit(input logic [15:0] a, input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        return (a >= base) && (d < dbl_pkg::TABLE_LEN);
    endfunction

    function automatic logic [3:0] f_idx(input logic [15:0] a, input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        return d[3:0];
    endfunction

    // Writes above the top level are stored as the top level.
    function automatic logic [7:0] f_sat(input logic [15:0] w);
        return (w > {8'h00, dbl_pkg::LVL_TOP}) ? dbl_pkg::LVL_TOP : w[7:0];
    endfunction

    // Whole next state: pick, step, write, read, mark changes, replace.
    always_comb begin
        logic [15:0] b_sp;
        logic [15:0] b_mn;
        logic [15:0] b_mx;
        logic [7:0] cur;
        b_sp = 16'h0000;
        b_mn = 16'h0000;
        b_mx = 16'h0000;
        cur = 8'h00;
        st_nxt = st_r;
        st_nxt.ack = 1'b0;
        st_nxt.cmd.vld = 1'b0;
        st_nxt.rep_go = 2'b00;
        sel_vld = 1'b0;
        sel_line = 1'b0;
        sel_idx = 4'h0;
        // Lowest pending ballast of line one goes first; a full sweep of
        // all 32 pending entries therefore takes 32 cycles.
        for (int l = dbl_pkg::NLINE - 1; l >= 0; l--) begin
            for (int b = dbl_pkg::NBAL - 1; b >= 0; b--) begin
                if (st_r.pend[l][b]) begin
                    sel_vld = 1'b1;
                    sel_line = 1'(l);
                    sel_idx = 4'(b);
                end
            end
        end
        sel_sp = st_r.sp[sel_line][sel_idx];
        sel_mn = st_r.mn[sel_line][sel_idx];
        sel_mx = st_r.mx[sel_line][sel_idx];
        if (sel_vld) begin
            st_nxt.cmd.vld = 1'b1; // R16
            st_nxt.cmd.line = sel_line;
            st_nxt.cmd.idx = sel_idx;
            st_nxt.cmd.lvl = f_clamp(sel_line, sel_sp, sel_mn, sel_mx);
            st_nxt.pend[sel_line][sel_idx] = 1'b0;
        end
        // Local switch step, ignored while the line's block bit is set.
        if (i_sw.vld && !i_dim_block[i_sw.line]) begin // R5
            cur = st_r.sp[i_sw.line][i_sw.idx];
            if (i_sw.up && cur < st_r.mx[i_sw.line][i_sw.idx]) begin // R11
                st_nxt.sp[i_sw.line][i_sw.idx] = cur + 8'h01;
            end else if (!i_sw.up && cur > st_r.mn[i_sw.line][i_sw.idx]) begin // R8
                st_nxt.sp[i_sw.line][i_sw.idx] = cur - 8'h01;
            end
        end
        // Register writes come after the switch so software wins a tie.
        for (int l = 0; l < dbl_pkg::NLINE; l++) begin
            b_sp = (l == 0) ? dbl_pkg::ADDR_SP1 : dbl_pkg::ADDR_SP2;
            b_mn = (l == 0) ? dbl_pkg::ADDR_MN1 : dbl_pkg::ADDR_MN2;
            b_mx = (l == 0) ? dbl_pkg::ADDR_MX1 : dbl_pkg::ADDR_MX2;
            if (i_req.wr && f_hit(i_req.addr, b_sp)) begin // R1 R2
                st_nxt.sp[l][f_idx(i_req.addr, b_sp)] = f_sat(i_req.wdata);
            end
            if (i_req.wr && f_hit(i_req.addr, b_mn)) begin // R6 R7
                st_nxt.mn[l][f_idx(i_req.addr, b_mn)] = f_sat(i_req.wdata);
            end
            if (i_req.wr && f_hit(i_req.addr, b_mx)) begin // R10 R12
                st_nxt.mx[l][f_idx(i_req.addr, b_mx)] = f_sat(i_req.wdata);
            end
            if (i_req.rd && f_hit(i_req.addr, b_sp)) begin
                st_nxt.rdata = {8'h00, st_r.sp[l][f_idx(i_req.addr, b_sp)]};
            end
            if (i_req.rd && f_hit(i_req.addr, b_mn)) begin
                st_nxt.rdata = {8'h00, st_r.mn[l][f_idx(i_req.addr, b_mn)]};
            end
            if (i_req.rd && f_hit(i_req.addr, b_mx)) begin
                st_nxt.rdata = {8'h00, st_r.mx[l][f_idx(i_req.addr, b_mx)]};
            end
            // A changed entry is marked after the clear, so a change in
            // the issue cycle still earns its own later command.
            for (int b = 0; b < dbl_pkg::NBAL; b++) begin
                if (st_nxt.sp[l][b] != st_r.sp[l][b] || st_nxt.mn[l][b] != st_r.mn[l][b]
                    || st_nxt.mx[l][b] != st_r.mx[l][b]) begin
                    st_nxt.pend[l][b] = 1'b1; // R16
                end
            end
            // Replacement fires once per rising edge and only with a fault.
            st_nxt.rep_prev[l] = i_replace_req[l];
            if (i_replace_req[l] && !st_r.rep_prev[l] && i_fault[l] != 16'h0000) begin
                st_nxt.rep_go[l] = 1'b1; // R15
            end
        end
        // Status reads; unmapped reads answer zero.
        if (i_req.rd) begin
            st_nxt.ack = 1'b1;
            case (i_req.addr)
                dbl_pkg::ADDR_FAULT1: st_nxt.rdata = i_fault[0]; // R14
                dbl_pkg::ADDR_FAULT2: st_nxt.rdata = i_fault[1]; // R14
                dbl_pkg::ADDR_COUNT1: st_nxt.rdata = i_count[0]; // R13
                dbl_pkg::ADDR_COUNT2: st_nxt.rdata = i_count[1]; // R13
                default: begin
                    if (!(f_hit(i_req.addr, dbl_pkg::ADDR_SP1) || f_hit(i_req.addr, dbl_pkg::ADDR_SP2)
                          || f_hit(i_req.addr, dbl_pkg::ADDR_MN1)
                          || f_hit(i_req.addr, dbl_pkg::ADDR_MN2)
                          || f_hit(i_req.addr, dbl_pkg::ADDR_MX1)
                          || f_hit(i_req.addr, dbl_pkg::ADDR_MX2))) begin
                        st_nxt.rdata = 16'h0000;
                    end
                end
            endcase
        end
        if (i_req.wr) begin
            st_nxt.ack = 1'b1;
        end
        // Synchronous reset loads the documented defaults.
        if (!i_reset_n) begin
            st_nxt = '0;
            // A request bit already high across reset is not a fresh edge.
            st_nxt.rep_prev = i_replace_req; // R15
            for (int l = 0; l < dbl_pkg::NLINE; l++) begin
                for (int b = 0; b < dbl_pkg::NBAL; b++) begin
                    st_nxt.sp[l][b] = dbl_pkg::SP_RST; // R1 R2
                    st_nxt.mn[l][b] = dbl_pkg::MN_RST; // R6
                    st_nxt.mx[l][b] = dbl_pkg::MX_RST; // R12
                end
            end
        end
    end

    // State register.
    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    // Outputs come straight from the state register.
    assign o_reg_rdata = st_r.rdata;
    assign o_reg_ack = st_r.ack;
    assign o_cmd = st_r.cmd;
    assign o_replace_go = st_r.rep_go;

    // Checks that tie outputs and stored values to their causes.
    a_max_after_reset: assert property (@(posedge i_clk) // R12
        !i_reset_n |=> st_r.mx[1][15] == 8'hFE && st_r.mx[0][0] == 8'hFE && st_r.sp[0][3] == 8'h00)
        else $error("high limit or setpoint default wrong after reset");

    a_cmd_under_max: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R11
        sel_vld && sel_mx < sel_sp |=> o_cmd.vld && o_cmd.lvl == $past(sel_mx))
        else $error("level above the high limit was not cut to it");

    a_cmd_over_min: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R9
        sel_vld && sel_sp != 8'h00 && sel_sp < sel_mn && sel_mn <= sel_mx
        |=> o_cmd.lvl == $past(sel_mn))
        else $error("level below the low limit was not raised to it");

    a_line1_off: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R3
        sel_vld && !sel_line && sel_sp == 8'h00 |=> o_cmd.vld && o_cmd.lvl == 8'h00)
        else $error("line one zero setpoint did not send off");

    a_line2_zero: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R4
        sel_vld && sel_line && sel_sp == 8'h00 && sel_mn <= sel_mx
        |=> o_cmd.line && o_cmd.lvl == $past(sel_mn))
        else $error("line two zero setpoint did not drive the minimum");

    a_write_issues_cmd: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R16
        i_req.wr && i_req.addr == 16'h9D4E && i_req.wdata[7:0] != st_r.sp[0][0]
        && i_req.wdata < 16'h00FF
        |-> ##[1:34] (o_cmd.vld && !o_cmd.line && o_cmd.idx == 4'h0))
        else $error("setpoint change gave no level command");

    a_block_holds: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R5
        i_sw.vld && i_dim_block[i_sw.line] && !i_req.wr
        |=> $stable(st_r.sp))
        else $error("blocked switch step changed a setpoint");

    a_step_up: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R11
        i_sw.vld && i_sw.up && !i_dim_block[i_sw.line] && !i_req.wr
        && st_r.sp[i_sw.line][i_sw.idx] >= st_r.mx[i_sw.line][i_sw.idx]
        |=> $stable(st_r.sp))
        else $error("switch brightened past the high limit");

    a_step_down: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R8
        i_sw.vld && !i_sw.up && !i_dim_block[i_sw.line] && !i_req.wr
        && st_r.sp[i_sw.line][i_sw.idx] > st_r.mn[i_sw.line][i_sw.idx]
        |=> st_r.sp[$past(i_sw.line)][$past(i_sw.idx)]
            == $past(st_r.sp[i_sw.line][i_sw.idx]) - 8'h01)
        else $error("switch step down missed by one");

    a_replace_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
        o_replace_go[0] |-> $past(i_fault[0]) != 16'h0000 && $past(i_replace_req[0])
        && !$past(i_replace_req[0], 2))
        else $error("replacement fired without fault or edge");

    a_replace_gate_two: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R15
        o_replace_go[1] |-> $past(i_fault[1]) != 16'h0000 && $past(i_replace_req[1])
        && !$past(i_replace_req[1], 2))
        else $error("second line replacement fired without fault or edge");

    a_target_saturate: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R1
        i_req.wr && i_req.addr == 16'h9D4F && i_req.wdata > 16'h00FE
        |=> st_r.sp[0][1] == 8'hFE)
        else $error("oversized setpoint write was not held at the top level");

    a_low_stored: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R6
        i_req.wr && i_req.addr == 16'h9DA0 && i_req.wdata < 16'h00FF
        |=> st_r.mn[1][2] == $past(i_req.wdata[7:0]))
        else $error("low limit write did not land");

    a_high_stored: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R10
        i_req.wr && i_req.addr == 16'h9DE1 && i_req.wdata < 16'h00FF
        |=> st_r.mx[1][3] == $past(i_req.wdata[7:0]))
        else $error("high limit write did not land");

    a_fault_read: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R14
        i_req.rd && i_req.addr == 16'h75CE |=> o_reg_ack && o_reg_rdata == $past(i_fault[1]))
        else $error("fault bitmap read returned wrong value");

    a_count_read: assert property (@(posedge i_clk) disable iff (!i_reset_n) // R13
        i_req.rd && i_req.addr == 16'h7632 |=> o_reg_rdata == $past(i_count[0]))
        else $error("addressed count read returned wrong value");

endmodule

// file: dbl_pkg.sv
/*
 * Shared constants and types for the two-line ballast level register bank.
 * Assumes one system clock; register numbers are the 16-bit register
 * numbers that the building management side uses on the register port.
 */
package dbl_pkg;

    // Structure of the bank.
    localparam int NLINE = 2;
    localparam int NBAL = 16;

    // Register numbers: read-only status words.
    localparam logic [15:0] ADDR_FAULT1 = 16'h75CD;
    localparam logic [15:0] ADDR_FAULT2 = 16'h75CE;
    localparam logic [15:0] ADDR_COUNT1 = 16'h7632;
    localparam logic [15:0] ADDR_COUNT2 = 16'h7633;

    // Register numbers: first ballast of each 16-entry table.
    localparam logic [15:0] ADDR_SP1 = 16'h9D4E;
    localparam logic [15:0] ADDR_SP2 = 16'h9D5E;
    localparam logic [15:0] ADDR_MN1 = 16'h9D8E;
    localparam logic [15:0] ADDR_MN2 = 16'h9D9E;
    localparam logic [15:0] ADDR_MX1 = 16'h9DCE;
    localparam logic [15:0] ADDR_MX2 = 16'h9DDE;
    localparam logic [15:0] TABLE_LEN = 16'h0010;

    // Level values and reset values.
    localparam logic [7:0] LVL_TOP = 8'hFE;
    localparam logic [7:0] LVL_OFF = 8'h00;
    localparam logic [7:0] SP_RST = 8'h00;
    localparam logic [7:0] MN_RST = 8'h00;
    localparam logic [7:0] MX_RST = 8'hFE;

    typedef logic [NLINE-1:0][NBAL-1:0][7:0] dbl_bank_t;

    // One register port request, same clock.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } dbl_req_t;

    // One local switch step request from the line's switch logic.
    typedef struct packed {
        logic vld;
        logic line;
        logic [3:0] idx;
        logic up;
    } dbl_sw_t;

    // One level command toward a ballast.
    typedef struct packed {
        logic vld;
        logic line;
        logic [3:0] idx;
        logic [7:0] lvl;
    } dbl_cmd_t;

    // Whole state of the bank.
    typedef struct packed {
        dbl_bank_t sp;
        dbl_bank_t mn;
        dbl_bank_t mx;
        logic [NLINE-1:0][NBAL-1:0] pend;
        logic [15:0] rdata;
        logic ack;
        dbl_cmd_t cmd;
        logic [NLINE-1:0] rep_prev;
        logic [NLINE-1:0] rep_go;
    } dbl_state_t;

endpackage

// file: tb_dbl_level_bank.sv
/*
 * Self-checking bench for the ballast level bank: register reads and
 * writes, clamped level commands, switch steps and replacement gating.
 * Assumes the line model beside it answers every command at once.
 */
`timescale 1ns/1ps

module tb_dbl_level_bank;
    logic i_clk;
    logic i_reset_n;
    dbl_pkg::dbl_req_t req;
    dbl_pkg::dbl_sw_t sw;
    logic [1:0] dim_block;
    logic [1:0] replace_req;
    logic [15:0] rdata;
    logic ack;
    logic [1:0][15:0] fault;
    logic [1:0][15:0] count;
    dbl_pkg::dbl_cmd_t cmd;
    logic [1:0] replace_go;
    logic [15:0] rd_val;
    int bad_count = 0;
    int checks = 0;
    int go_cnt [2] = '{0, 0};
    int n;

    dbl_level_bank dut_u (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_req(req),
        .o_reg_rdata(rdata), .o_reg_ack(ack), .i_fault(fault), .i_count(count),
        .i_sw(sw), .i_dim_block(dim_block), .i_replace_req(replace_req),
        .o_cmd(cmd), .o_replace_go(replace_go));
    dbl_ballast_model partner_u (.i_clk(i_clk), .i_cmd(cmd), .o_fault(fault),
        .o_count(count));

    // Free-running system clock, 40 ns period.
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Replacement pulses are counted so that a missed or doubled one shows.
    always @(posedge i_clk) begin
        for (int l = 0; l < 2; l++) begin
            if (replace_go[l] === 1'b1) begin
                go_cnt[l] <= go_cnt[l] + 1;
            end
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One register access; the answer is taken one cycle after the strobe.
    task automatic reg_acc(input logic wr, input logic [15:0] addr, input logic [15:0] data);
        @(posedge i_clk);
        req <= '{wr: wr, rd: ~wr, addr: addr, wdata: data};
        @(posedge i_clk);
        req <= '0;
        #1;
        check("ack", {15'h0000, ack}, 16'h0001);
        rd_val = rdata;
    endtask

    task automatic rd_chk(input string what, input logic [15:0] addr, input logic [15:0] exp);
        reg_acc(1'b0, addr, 16'h0000);
        check(what, rd_val, exp);
    endtask

    task automatic idle(input int cyc);
        repeat (cyc) @(posedge i_clk);
    endtask

    // Waits past the longest pending sweep, then asks the ballast model.
    task automatic lvl_chk(input int line, input int idx, input logic [7:0] exp);
        idle(40);
        check("level", {8'h00, partner_u.level_q[line][idx]}, {8'h00, exp});
    endtask

    task automatic step(input logic line, input logic [3:0] idx, input logic up);
        @(posedge i_clk);
        sw <= '{vld: 1'b1, line: line, idx: idx, up: up};
        @(posedge i_clk);
        sw <= '0;
    endtask

    task automatic print_verdict;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Cuts a hang short well beyond the fewer than a thousand cycles the tests need.
    initial begin
        #2000000;
        bad_count = bad_count + 1;
        print_verdict();
    end

    // Main sequence: reset, tables, status, clamping, switches, replacement.
    initial begin
        i_reset_n = 1'b0;
        req = '0;
        sw = '0;
        dim_block = 2'b00;
        replace_req = 2'b00;
        idle(8);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            rd_chk("target1", dbl_pkg::ADDR_SP1 + 16'(i), 16'h0000);
            rd_chk("target2", dbl_pkg::ADDR_SP2 + 16'(i), 16'h0000);
            rd_chk("low1", dbl_pkg::ADDR_MN1 + 16'(i), 16'h0000);
            rd_chk("low2", dbl_pkg::ADDR_MN2 + 16'(i), 16'h0000);
            rd_chk("high1", dbl_pkg::ADDR_MX1 + 16'(i), 16'h00FE);
            rd_chk("high2", dbl_pkg::ADDR_MX2 + 16'(i), 16'h00FE);
        end
        reg_acc(1'b1, 16'h9D6E, 16'h0055);
        rd_chk("unmapped", 16'h9D6E, 16'h0000);
        reg_acc(1'b1, dbl_pkg::ADDR_SP1 + 16'h000F, 16'h0033);
        rd_chk("last target", dbl_pkg::ADDR_SP1 + 16'h000F, 16'h0033);
        rd_chk("next table", dbl_pkg::ADDR_SP2, 16'h0000);
        partner_u.set_status(0, 16'h8001, 16'h000C);
        partner_u.set_status(1, 16'h0002, 16'h0005);
        rd_chk("fault1", dbl_pkg::ADDR_FAULT1, 16'h8001);
        rd_chk("fault2", dbl_pkg::ADDR_FAULT2, 16'h0002);
        rd_chk("count1", dbl_pkg::ADDR_COUNT1, 16'h000C);
        reg_acc(1'b1, dbl_pkg::ADDR_COUNT2, 16'h0077);
        rd_chk("count2", dbl_pkg::ADDR_COUNT2, 16'h0005);
        reg_acc(1'b1, dbl_pkg::ADDR_SP1, 16'h0080);
        rd_chk("target", dbl_pkg::ADDR_SP1, 16'h0080);
        lvl_chk(0, 0, 8'h80);
        reg_acc(1'b1, dbl_pkg::ADDR_SP1 + 16'h0001, 16'h00FF);
        rd_chk("saturated", dbl_pkg::ADDR_SP1 + 16'h0001, 16'h00FE);
        lvl_chk(0, 1, 8'hFE);
        n = partner_u.cmd_total;
        reg_acc(1'b1, dbl_pkg::ADDR_SP1 + 16'h0001, 16'h00FE);
        idle(40);
        check("repeat write", 16'(partner_u.cmd_total), 16'(n));
        reg_acc(1'b1, dbl_pkg::ADDR_MN1 + 16'h0002, 16'h0005);
        lvl_chk(0, 2, 8'h00);
        reg_acc(1'b1, dbl_pkg::ADDR_MN2 + 16'h0002, 16'h0005);
        lvl_chk(1, 2, 8'h05);
        reg_acc(1'b1, dbl_pkg::ADDR_MN2 + 16'h0003, 16'h0040);
        reg_acc(1'b1, dbl_pkg::ADDR_SP2 + 16'h0003, 16'h0010);
        lvl_chk(1, 3, 8'h40);
        step(1'b1, 4'h3, 1'b0);
        rd_chk("below low", dbl_pkg::ADDR_SP2 + 16'h0003, 16'h0010);
        reg_acc(1'b1, dbl_pkg::ADDR_MX2 + 16'h0003, 16'h0060);
        reg_acc(1'b1, dbl_pkg::ADDR_SP2 + 16'h0003, 16'h0090);
        lvl_chk(1, 3, 8'h60);
        step(1'b1, 4'h3, 1'b1);
        rd_chk("above high", dbl_pkg::ADDR_SP2 + 16'h0003, 16'h0090);
        reg_acc(1'b1, dbl_pkg::ADDR_MN2 + 16'h0004, 16'h0040);
        reg_acc(1'b1, dbl_pkg::ADDR_SP2 + 16'h0004, 16'h0041);
        step(1'b1, 4'h4, 1'b0);
        step(1'b1, 4'h4, 1'b0);
        rd_chk("dim floor", dbl_pkg::ADDR_SP2 + 16'h0004, 16'h0040);
        lvl_chk(1, 4, 8'h40);
        @(posedge i_clk);
        dim_block <= 2'b10;
        step(1'b1, 4'h5, 1'b1);
        rd_chk("blocked", dbl_pkg::ADDR_SP2 + 16'h0005, 16'h0000);
        @(posedge i_clk);
        dim_block <= 2'b00;
        step(1'b1, 4'h5, 1'b1);
        rd_chk("unblocked", dbl_pkg::ADDR_SP2 + 16'h0005, 16'h0001);
        lvl_chk(1, 5, 8'h01);
        reg_acc(1'b1, dbl_pkg::ADDR_MX1 + 16'h0006, 16'h0001);
        reg_acc(1'b1, dbl_pkg::ADDR_SP1 + 16'h0006, 16'h0080);
        lvl_chk(0, 6, 8'h01);
        partner_u.set_status(1, 16'h0000, 16'h0005);
        replace_req <= 2'b10;
        idle(4);
        check("go no fault", 16'(go_cnt[1]), 16'h0000);
        replace_req <= 2'b00;
        partner_u.set_status(1, 16'h0002, 16'h0005);
        replace_req <= 2'b10;
        idle(6);
        check("go fault", 16'(go_cnt[1]), 16'h0001);
        check("go other line", 16'(go_cnt[0]), 16'h0000);
        // Line one rises with its faults set while line two is only held high.
        replace_req <= 2'b11;
        idle(6);
        check("go line one", 16'(go_cnt[0]), 16'h0001);
        check("go held level", 16'(go_cnt[1]), 16'h0001);
        print_verdict();
    end
endmodule
